// ---- hw/rlc_pkg.sv ----
// Package for the receive loopback code detector: offsets, fields, resets, types
package rlc_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [11:0] RLC_IDX_CODE_CTRL = 12'h124;
   localparam logic [11:0] RLC_IDX_ACT_PAT = 12'h126;
   localparam logic [11:0] RLC_IDX_DEACT_PAT = 12'h127;
   localparam logic [11:0] RLC_IDX_STATUS = 12'h128;
   localparam int RLC_IDX_LSB = 2;
   localparam int RLC_IDX_MSB = 13;

   // ==========================================================
   // Field positions
   localparam int RLC_PAT_MSB = 7;
   localparam int RLC_PAT_LSB = 1;
   localparam int RLC_PAT_EN_BIT = 0;
   localparam int RLC_CTRL_AUTO_BIT = 0;
   localparam int RLC_CTRL_FRAMED_BIT = 1;
   localparam int RLC_CTRL_LEN_LSB = 2;
   localparam int RLC_CTRL_LEN_MSB = 3;
   localparam int RLC_ST_LOOP_BIT = 0;
   localparam int RLC_ST_ACT_BIT = 1;
   localparam int RLC_ST_DEACT_BIT = 2;

   // ==========================================================
   // Reset values and sizes
   localparam logic [7:0] RLC_PAT_RST = 8'haa;
   localparam logic [7:0] RLC_CTRL_RST = 8'h00;
   localparam logic [6:0] RLC_CODE_MASK_FULL = 7'h7f;
   localparam logic [2:0] RLC_CODE_MAX_LEN = 3'h7;
   localparam logic [2:0] RLC_CODE_LEN_SHIFT_MAX = 3'h3;
   localparam logic [1:0] RLC_RESP_OKAY = 2'h0;
   localparam logic [1:0] RLC_RESP_SLVERR = 2'h2;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [1:0] len_sel;
      logic framed;
      logic auto_remote_loop;
   } rlc_ctrl_type;

   typedef struct packed {
      logic [6:0] code;
      logic detect_on;
   } rlc_pat_type;

   typedef struct packed {
      logic bit_valid;
      logic bit_value;
      logic framing_slot;
   } rlc_line_type;
endpackage : rlc_pkg

// ---- hw/rlc_detector.sv ----
// Receive loopback code detector with AXI4-Lite register access
`timescale 1ns/10ps
module rlc_detector
   import rlc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Receive line bit stream
   input wire rlc_line_type line_in,
   // Detection results
   output logic activate_hit,
   output logic deactivate_hit,
   output logic remote_loop_on
);

   // ==========================================================
   // Register state
   rlc_pat_type act_q;
   rlc_pat_type deact_q;
   rlc_ctrl_type ctrl_q;
   logic act_seen_q;
   logic deact_seen_q;
   logic loop_q;
   logic [6:0] shift_q;
   logic [2:0] fill_q;
   logic [1:0] hit_q;
   logic [1:0] hit_d;

   // AXI bookkeeping
   logic aw_held_q;
   logic w_held_q;
   logic [11:0] aw_idx_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic [1:0] bresp_q;
   logic bvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;
   logic do_write;
   logic ar_take;
   logic [11:0] ar_idx;

   // ==========================================================
   // Write channel: address and data accepted in either order
   assign do_write = aw_held_q && w_held_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_idx_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[RLC_IDX_MSB:RLC_IDX_LSB];
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Ready stays high while the holding slot is empty
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;

   // Write response, one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RLC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         case (aw_idx_q)
            RLC_IDX_CODE_CTRL, RLC_IDX_ACT_PAT, RLC_IDX_DEACT_PAT,
            RLC_IDX_STATUS: bresp_q <= RLC_RESP_OKAY;
            default: bresp_q <= RLC_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ==========================================================
   // Control registers; all fields live in byte lane 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q <= RLC_PAT_RST;
         deact_q <= RLC_PAT_RST;
         ctrl_q <= rlc_ctrl_type'(RLC_CTRL_RST[3:0]);
      end else if (do_write && wstrb0_q) begin
         case (aw_idx_q)
            RLC_IDX_ACT_PAT: begin
               act_q.code <= wdata_q[RLC_PAT_MSB:RLC_PAT_LSB];
               act_q.detect_on <= wdata_q[RLC_PAT_EN_BIT];
            end
            RLC_IDX_DEACT_PAT: begin
               deact_q.code <= wdata_q[RLC_PAT_MSB:RLC_PAT_LSB];
               deact_q.detect_on <= wdata_q[RLC_PAT_EN_BIT];
            end
            RLC_IDX_CODE_CTRL: begin
               ctrl_q.len_sel <= wdata_q[RLC_CTRL_LEN_MSB:RLC_CTRL_LEN_LSB];
               ctrl_q.framed <= wdata_q[RLC_CTRL_FRAMED_BIT];
               ctrl_q.auto_remote_loop <= wdata_q[RLC_CTRL_AUTO_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Read channel: data one cycle after the address is taken
   assign ar_take = s_axi_arvalid && !rvalid_q;
   assign ar_idx = s_axi_araddr[RLC_IDX_MSB:RLC_IDX_LSB];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RLC_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rresp_q <= RLC_RESP_OKAY;
         case (ar_idx)
            RLC_IDX_ACT_PAT: rdata_q <= {24'h000000, act_q};
            RLC_IDX_DEACT_PAT: rdata_q <= {24'h000000, deact_q};
            RLC_IDX_CODE_CTRL: rdata_q <= {28'h0000000, ctrl_q};
            RLC_IDX_STATUS: rdata_q <= {29'h0000000, deact_seen_q, act_seen_q, loop_q};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= RLC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ==========================================================
   // Line history; framing slots are skipped in framed mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_q <= 7'h00;
         fill_q <= 3'h0;
      end else if (line_in.bit_valid && !(ctrl_q.framed && line_in.framing_slot)) begin
         shift_q <= {shift_q[5:0], line_in.bit_value};
         if (fill_q != RLC_CODE_MAX_LEN) begin
            fill_q <= fill_q + 3'h1;
         end
      end
   end

   // ==========================================================
   // Both comparators share one length; code sits in the upper bits
   for (genvar g = 0; g < 2; g++) begin : g_cmp
      rlc_pat_type pat;
      logic [2:0] drop;
      logic [6:0] mask;
      logic [6:0] want;
      assign pat = (g == 0) ? act_q : deact_q;
      assign drop = RLC_CODE_LEN_SHIFT_MAX - {1'b0, ctrl_q.len_sel};
      assign mask = RLC_CODE_MASK_FULL >> drop;
      // Newest bit is the code LSB, so the MSB arrived first
      assign want = pat.code >> drop;
      assign hit_d[g] = pat.detect_on && line_in.bit_valid
         && !(ctrl_q.framed && line_in.framing_slot)
         && (fill_q >= ({1'b0, ctrl_q.len_sel} + 3'h3))
         && ((({shift_q[5:0], line_in.bit_value} ^ want) & mask) == 7'h00);
   end

   // Registered event pulses, one per matching bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit_q <= 2'b00;
      end else begin
         hit_q <= hit_d;
      end
   end

   assign activate_hit = hit_q[0];
   assign deactivate_hit = hit_q[1];

   // ==========================================================
   // Sticky detection flags; a new hit beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_seen_q <= 1'b0;
         deact_seen_q <= 1'b0;
      end else begin
         if (hit_q[0]) begin
            act_seen_q <= 1'b1;
         end else if (do_write && wstrb0_q && aw_idx_q == RLC_IDX_STATUS
                      && wdata_q[RLC_ST_ACT_BIT]) begin
            act_seen_q <= 1'b0;
         end
         if (hit_q[1]) begin
            deact_seen_q <= 1'b1;
         end else if (do_write && wstrb0_q && aw_idx_q == RLC_IDX_STATUS
                      && wdata_q[RLC_ST_DEACT_BIT]) begin
            deact_seen_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Automatic remote loopback; turning auto off drops the loop so it
   // cannot stay stuck with no way to leave it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_q <= 1'b0;
      end else if (!ctrl_q.auto_remote_loop) begin
         loop_q <= 1'b0;
      end else if (hit_q[1]) begin
         loop_q <= 1'b0;
      end else if (hit_q[0]) begin
         loop_q <= 1'b1;
      end
   end

   assign remote_loop_on = loop_q;

endmodule : rlc_detector

// ---- testbench/rlc_checker_assertions.sv ----
// Port checker for the receive loopback code detector
`timescale 1ns/10ps
module rlc_checker
   import rlc_pkg::*;
(
   // Clock, reset and bus answers
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Line and results
   input wire rlc_line_type line_in,
   input wire logic activate_hit,
   input wire logic deactivate_hit,
   input wire logic remote_loop_on
);
   // ==========================================
   // Steps of leaving the loop
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_leave;
      deactivate_hit ##1 !remote_loop_on;
   endsequence
   AST_B_HOLD:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_R_CAUSE:
   assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
      else $error("read answer without request");
   AST_AR_BLOCK:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   AST_ACT_CAUSE:
   assert property (activate_hit |-> $past(line_in.bit_valid))
      else $error("activation hit without a line bit");
   AST_DEACT_CAUSE:
   assert property (deactivate_hit |-> $past(line_in.bit_valid))
      else $error("deactivation hit without a line bit");
   AST_LOOP_ENTER:
   assert property ($rose(remote_loop_on) |-> $past(activate_hit))
      else $error("loop entered without activation");
   AST_LOOP_LEAVE:
   assert property (deactivate_hit |-> s_leave)
      else $error("loop kept after deactivation");
endmodule : rlc_checker
bind rlc_detector rlc_checker i_rlc_checker (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .line_in, .activate_hit, .deactivate_hit, .remote_loop_on);

// ---- testbench/rlc_far_end.sv ----
// Far terminal model sending the received line bit stream
`timescale 1ns/10ps
module rlc_far_end
   import rlc_pkg::*;
(
   // Clock and pacing
   input wire logic aclk,
   input wire logic run,
   input wire logic slow,
   // Line towards the detector
   output rlc_line_type line_out
);
   int seed = 94;
   initial line_out = '0;
   // Idle slots show the inverse bit, so a stale value never matches by luck
   always @(posedge aclk) begin
      if (run && (!slow || ($random(seed) % 2) != 0)) begin
         line_out.bit_valid <= 1'b1;
         line_out.bit_value <= 1'($random(seed));
         line_out.framing_slot <= ($random(seed) % 8) == 0;
      end else begin
         line_out.bit_valid <= 1'b0;
         line_out.bit_value <= !line_out.bit_value;
      end
   end
endmodule : rlc_far_end

// ---- testbench/testbench.sv ----
// Self-checking bench for the receive loopback code detector
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", n, e, s); end end
module testbench
   import rlc_pkg::*;
;
   // ==========================================
   // Signals and model state
   logic aclk = 0, aresetn = 0, run = 0, slow = 0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, activate_hit, deactivate_hit, remote_loop_on;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, ea = 0, ed = 0;
   logic [7:0] ctrl = 0, code_a = 8'haa, code_d = 8'haa;
   logic loop_m = 0, sa = 0, sd = 0;
   rlc_line_type line_in;
   int err_count = 0, checks_done = 0, seed = 94, hist, nbits, len;
   rlc_detector i_rlc_detector (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .line_in, .activate_hit, .deactivate_hit, .remote_loop_on);
   rlc_far_end i_rlc_far_end (.aclk, .run, .slow, .line_out(line_in));
   always #25 aclk = !aclk;
   // Model: a hit stands the cycle after its bit, loop and flags follow one edge later
   always @(posedge aclk) begin
      len = 4 + ctrl[3:2];
      if (!aresetn) begin
         hist = 0;
         nbits = 0;
         ea = 0;
         ed = 0;
         loop_m = 0;
         sa = 0;
         sd = 0;
      end else begin
         `CHK("activate_hit", ea[0], activate_hit)
         `CHK("deactivate_hit", ed[0], deactivate_hit)
         if (run) `CHK("remote_loop_on", loop_m, remote_loop_on)
         if (!ctrl[0] || ed[0]) loop_m = 0;
         else if (ea[0]) loop_m = 1;
         if (ea[0]) sa = 1;
         if (ed[0]) sd = 1;
         ea = 0;
         ed = 0;
         if (line_in.bit_valid && !(ctrl[1] && line_in.framing_slot)) begin
            hist = (hist << 1) | line_in.bit_value;
            nbits++;
            ea[0] = code_a[0] && nbits >= len && (hist & ((1 << len) - 1)) == code_a >> (8 - len);
            ed[0] = code_d[0] && nbits >= len && (hist & ((1 << len) - 1)) == code_d >> (8 - len);
         end
      end
   end
   function automatic logic [31:0] ba(input logic [11:0] i);
      return {18'h0, i, 2'h0};
   endfunction : ba
   // Bus tasks; waits end only by the watchdog
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      `CHK("write resp", er, s_axi_bresp)
      s_axi_bready <= 0;
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      `CHK("read data", {24'h0, e}, s_axi_rdata)
      `CHK("read resp", er, s_axi_rresp)
      s_axi_rready <= 0;
   endtask : rd
   task automatic end_of_test();
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   // Watchdog well beyond the expected run
   initial begin
      #1000000;
      err_count++;
      end_of_test();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rd(ba(RLC_IDX_ACT_PAT), RLC_PAT_RST, RLC_RESP_OKAY);
      rd(ba(RLC_IDX_DEACT_PAT), RLC_PAT_RST, RLC_RESP_OKAY);
      rd(ba(RLC_IDX_CODE_CTRL), 8'h00, RLC_RESP_OKAY);
      rd(ba(12'h129), 8'h00, RLC_RESP_SLVERR);
      wr(ba(12'h129), 8'hff, RLC_RESP_SLVERR);
      // Lane 0 strobe low: write answered but ignored
      s_axi_wstrb <= 4'h0;
      wr(ba(RLC_IDX_ACT_PAT), 8'h55, RLC_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(ba(RLC_IDX_ACT_PAT), RLC_PAT_RST, RLC_RESP_OKAY);
      // Every length, both formats, random codes and pacing
      for (int k = 0; k < 8; k++) begin
         ctrl = {4'h0, 2'(k), 1'(k / 4), 1'($random(seed))};
         wr(ba(RLC_IDX_CODE_CTRL), ctrl, RLC_RESP_OKAY);
         code_a = {7'($random(seed)), 1'b0};
         wr(ba(RLC_IDX_ACT_PAT), code_a, RLC_RESP_OKAY);
         code_a[0] = 1;
         wr(ba(RLC_IDX_ACT_PAT), code_a, RLC_RESP_OKAY);
         rd(ba(RLC_IDX_ACT_PAT), code_a, RLC_RESP_OKAY);
         code_d = {7'($random(seed)), 1'(k != 3)};
         wr(ba(RLC_IDX_DEACT_PAT), code_d, RLC_RESP_OKAY);
         rd(ba(RLC_IDX_DEACT_PAT), code_d, RLC_RESP_OKAY);
         slow <= 1'($random(seed));
         run <= 1;
         repeat (600) @(posedge aclk);
         // Let the last bit settle, then check and clear the sticky flags
         run <= 0;
         repeat (4) @(posedge aclk);
         rd(ba(RLC_IDX_STATUS), {5'h0, sd, sa, loop_m}, RLC_RESP_OKAY);
         wr(ba(RLC_IDX_STATUS), 8'h06, RLC_RESP_OKAY);
         sa = 0;
         sd = 0;
         rd(ba(RLC_IDX_STATUS), {5'h0, 2'b00, loop_m}, RLC_RESP_OKAY);
      end
      end_of_test();
   end
endmodule : testbench
